// *** logic/cdu_pkg.sv ***
// constants, types and layout of the configuration download and update block
// assumes one system clock domain plus the serial link clock, async active high reset
package cdu_pkg;
   // timing, in the system clock of 20 MHz
   localparam int unsigned T_SYS_NS = 50;
   localparam int unsigned PWR_WAIT_NS = 500000;
   localparam int unsigned PWR_WAIT_CYC = PWR_WAIT_NS / T_SYS_NS;
   localparam int unsigned SE_FETCH_NS = 10000;
   localparam int unsigned SE_FETCH_CYC = SE_FETCH_NS / T_SYS_NS;
   // memory sizes
   localparam int unsigned RAM_BYTES = 224;
   localparam int unsigned EE_BYTES = 1024;
   localparam int unsigned PAGE_BYTES = 32;
   // register map
   localparam logic [7:0] UPD_CTRL_ADDR = 8'h90;
   localparam logic [7:0] UDL_ADDR = 8'hD8;
   localparam logic [7:0] ID_MAKER_ADDR = 8'hF4;
   localparam logic [7:0] ID_REV_ADDR = 8'hF5;
   localparam logic [7:0] ID_BRAND_MARK_ONE_ADDR = 8'hF6;
   localparam logic [7:0] ID_BRAND_MARK_TWO_ADDR = 8'hF7;
   localparam logic [7:0] RAM_LIMIT = 8'hE0;
   localparam logic [5:0] EE_HI_TAG = 6'h3E;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'hFE;
   localparam logic [7:0] EE_BLANK = 8'hFF;
   localparam logic [4:0] SLV_ADDR_HI = 5'h0D;
   localparam logic [5:0] SE_RESERVED = 6'h3F;
   // field positions and reset values
   localparam int unsigned UPD_TRANSP = 0;
   localparam int unsigned UPD_COMMIT = 1;
   localparam int unsigned UPD_ERASE_EN = 2;
   localparam int unsigned UDL_GO = 0;
   localparam logic [7:0] UPD_STORE_MASK = 8'h05;
   localparam logic [7:0] UPD_CTRL_RST = 8'h00;
   localparam logic [7:0] UDL_RST = 8'h00;
   // system side sequence
   typedef enum logic [2:0] {
      CDU_DL = 3'b000, CDU_XFER = 3'b001, CDU_WAIT = 3'b010,
      CDU_FETCH = 3'b011, CDU_RUN = 3'b100, CDU_ERASE = 3'b101
   } cdu_state_t;
   // link side byte framing
   typedef enum logic [1:0] {
      CDU_L_IDLE = 2'b00, CDU_L_ADDR = 2'b01, CDU_L_WDATA = 2'b10, CDU_L_RDATA = 2'b11
   } cdu_lstate_t;
   // one received write byte, handed from link to system side
   typedef struct packed {
      logic first;
      logic [7:0] data;
   } cdu_byte_t;
endpackage : cdu_pkg

// *** logic/cdu_top.sv ***
// configuration latches, nonvolatile store, download sequencer and serial slave
// assumes scl_clk_i is the bus clock pin used as a clock; sda is open drain outside
`timescale 1ns/100ps
module cdu_top import cdu_pkg::*; #(
   parameter int unsigned PWR_WAIT = PWR_WAIT_CYC,
   parameter logic [7:0] MAKER_ID = 8'h5A,  // arbitrary value
   parameter logic [7:0] SILICON_REV = 8'h12,  // arbitrary value
   parameter logic [7:0] BRAND_ONE = 8'h34,  // arbitrary value
   parameter logic [7:0] BRAND_TWO = 8'h56  // arbitrary value
) (
   // system clock and lockout reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // serial bus
   input wire logic scl_clk_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_drv_n_o,
   input wire logic addr_select_hi_pin_i,
   input wire logic addr_select_lo_pin_i,
   // sequencing engine
   input wire logic se_advance_i,
   input wire logic [5:0] se_next_idx_i,
   output logic [63:0] se_state_o,
   output logic [5:0] se_index_o,
   // active configuration lookup
   input wire logic [7:0] cfg_rd_addr_i,
   output logic [7:0] cfg_rd_data_o,
   output logic dl_busy_o
);
   localparam int FETCH_LO = int'(SE_FETCH_CYC);
   localparam int FETCH_HI = int'(SE_FETCH_CYC) + 1;

   // pointer lies in the nonvolatile window
   function automatic logic in_ee(input logic [15:0] a);
      in_ee = (a[15:10] == EE_HI_TAG);
   endfunction : in_ee

   // link side state
   logic start_tg_ff, start_seen_ff, nxt_seen;
   cdu_lstate_t lst_ff, nxt_lst;
   logic [3:0] cnt_l_ff, nxt_cnt_l;
   logic [7:0] sh_ff, nxt_sh, rd_sh_ff, nxt_rd_sh, byte_w;
   logic ack_ff, nxt_ack, first_ff, nxt_first, evt_tg_ff, nxt_evt_tg;
   cdu_byte_t evt_ff, nxt_evt;
   logic drv_n_ff, nxt_drv_n, sda_o_ff;
   logic bsy_m_ff, bsy_s_ff;
   logic [1:0] pin_m_ff, pin_s_ff;
   // system side state
   cdu_state_t st_ff, nxt_st;
   logic [13:0] cnt_ff, nxt_cnt;
   logic [15:0] ptr_ff, nxt_ptr;
   logic exp_lo_ff, nxt_exp_lo, pwr_ff, nxt_pwr, busy_ff;
   logic [7:0] ctrl_ff, nxt_ctrl, udl_ff, nxt_udl, rd_data_ff, nxt_rd_data, cfg_rd_ff;
   logic [5:0] se_idx_ff, nxt_se_idx;
   logic [63:0] se_word_ff, nxt_se_word, fetch_w;
   logic tg_m_ff, tg_s_ff, tg_d_ff, new_byte;
   // memories and their write ports
   logic [7:0] latch_a [RAM_BYTES];
   logic [7:0] latch_b [RAM_BYTES];
   logic [7:0] ee_mem [EE_BYTES];
   logic a_we, b_we, b_copy, ee_we, bus_ram_wr, bus_ee_wr;
   logic [7:0] a_addr, a_din, b_addr, b_din, ee_din;
   logic [9:0] ee_addr;

   // start marker: sda falling while scl high, toggled on sda itself
   always_ff @(negedge sda_i or posedge rst_i) begin
      if (rst_i) begin
         start_tg_ff <= 1'b0;
      end else if (scl_clk_i) begin
         start_tg_ff <= ~start_tg_ff;
      end
   end

   // synchronisers into the link domain; lockout flag and address pins
   always_ff @(posedge scl_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bsy_m_ff <= 1'b1;
         bsy_s_ff <= 1'b1;
         pin_m_ff <= 2'h0;
         pin_s_ff <= 2'h0;
      end else begin
         bsy_m_ff <= busy_ff;
         bsy_s_ff <= bsy_m_ff;
         pin_m_ff <= {addr_select_hi_pin_i, addr_select_lo_pin_i};
         pin_s_ff <= pin_m_ff;
      end
   end

   // link framing, sampled on rising scl while data is stable
   always_comb begin
      nxt_seen = start_seen_ff;
      nxt_lst = lst_ff;
      nxt_cnt_l = cnt_l_ff;
      byte_w = {sh_ff[6:0], sda_i};
      nxt_sh = byte_w;
      nxt_rd_sh = rd_sh_ff;
      nxt_ack = ack_ff;
      nxt_first = first_ff;
      nxt_evt_tg = evt_tg_ff;
      nxt_evt = evt_ff;
      if (start_tg_ff != start_seen_ff) begin
         // this edge carries the first address bit
         nxt_seen = start_tg_ff;
         nxt_lst = CDU_L_ADDR;
         nxt_cnt_l = 4'h1;
         nxt_ack = 1'b0;
      end else if (lst_ff == CDU_L_IDLE) begin
         nxt_ack = 1'b0;
      end else if (cnt_l_ff == 4'h8) begin
         // ninth bit: acknowledge slot
         nxt_cnt_l = 4'h0;
         nxt_ack = 1'b0;
         if (lst_ff == CDU_L_RDATA) begin
            if (!ack_ff && sda_i) begin
               nxt_lst = CDU_L_IDLE;
            end else begin
               nxt_rd_sh = rd_data_ff;  // held steady by the system side
            end
         end
      end else begin
         nxt_cnt_l = 4'(cnt_l_ff + 4'h1);
         nxt_rd_sh = {rd_sh_ff[6:0], 1'b1};
         if (cnt_l_ff == 4'h7) begin
            case (lst_ff)
               CDU_L_ADDR: begin
                  if (byte_w[7:1] == {SLV_ADDR_HI, pin_s_ff} && !bsy_s_ff) begin
                     nxt_ack = 1'b1;
                     nxt_first = 1'b1;
                     nxt_lst = byte_w[0] ? CDU_L_RDATA : CDU_L_WDATA;
                  end else begin
                     nxt_lst = CDU_L_IDLE;
                  end
               end
               CDU_L_WDATA: begin
                  if (!bsy_s_ff) begin
                     nxt_ack = 1'b1;
                     nxt_evt = '{first: first_ff, data: byte_w};
                     nxt_evt_tg = ~evt_tg_ff;
                     nxt_first = 1'b0;
                  end else begin
                     nxt_lst = CDU_L_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge scl_clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_seen_ff <= 1'b0;
         lst_ff <= CDU_L_IDLE;
         cnt_l_ff <= 4'h0;
         sh_ff <= 8'h00;
         rd_sh_ff <= 8'hFF;
         ack_ff <= 1'b0;
         first_ff <= 1'b0;
         evt_tg_ff <= 1'b0;
         evt_ff <= '0;
      end else begin
         start_seen_ff <= nxt_seen;
         lst_ff <= nxt_lst;
         cnt_l_ff <= nxt_cnt_l;
         sh_ff <= nxt_sh;
         rd_sh_ff <= nxt_rd_sh;
         ack_ff <= nxt_ack;
         first_ff <= nxt_first;
         evt_tg_ff <= nxt_evt_tg;
         evt_ff <= nxt_evt;
      end
   end

   // data pin changes only while scl is low
   always_comb begin
      nxt_drv_n = 1'b1;
      if (cnt_l_ff == 4'h8 && ack_ff) begin
         nxt_drv_n = 1'b0;
      end else if (lst_ff == CDU_L_RDATA && cnt_l_ff < 4'h8 && !rd_sh_ff[7]) begin
         nxt_drv_n = 1'b0;
      end
   end

   always_ff @(negedge scl_clk_i or posedge rst_i) begin
      if (rst_i) begin
         drv_n_ff <= 1'b1;
         sda_o_ff <= 1'b0;
      end else begin
         drv_n_ff <= nxt_drv_n;
         sda_o_ff <= 1'b0;
      end
   end

   // byte event toggle into the system domain; payload is stable for a whole byte
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tg_m_ff <= 1'b0;
         tg_s_ff <= 1'b0;
         tg_d_ff <= 1'b0;
      end else begin
         tg_m_ff <= evt_tg_ff;
         tg_s_ff <= tg_m_ff;
         tg_d_ff <= tg_s_ff;
      end
   end
   assign new_byte = tg_s_ff ^ tg_d_ff;

   always_comb begin
      fetch_w = '0;
      for (int k = 0; k < 8; k++) begin
         fetch_w[k*8 +: 8] = ee_mem[{1'b1, se_idx_ff, 3'(k)}];
      end
   end

   // download, sequencer fetch and register write decode
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_ptr = ptr_ff;
      nxt_exp_lo = exp_lo_ff;
      nxt_pwr = pwr_ff;
      nxt_ctrl = ctrl_ff;
      nxt_udl = udl_ff;
      nxt_se_idx = se_idx_ff;
      nxt_se_word = se_word_ff;
      a_we = 1'b0;
      a_addr = ptr_ff[7:0];
      a_din = evt_ff.data;
      b_we = 1'b0;
      b_copy = 1'b0;
      ee_we = 1'b0;
      ee_addr = ptr_ff[9:0];
      ee_din = evt_ff.data;
      bus_ram_wr = 1'b0;
      bus_ee_wr = 1'b0;
      case (st_ff)
         CDU_DL: begin
            a_we = 1'b1;
            a_addr = cnt_ff[7:0];
            a_din = ee_mem[{2'b00, cnt_ff[7:0]}];
            if (cnt_ff == 14'(RAM_BYTES - 1)) begin
               nxt_cnt = 14'h0000;
               nxt_st = CDU_XFER;
            end else begin
               nxt_cnt = 14'(cnt_ff + 14'h0001);
            end
         end
         CDU_XFER: begin
            b_copy = 1'b1;
            nxt_udl[UDL_GO] = 1'b0;
            nxt_st = pwr_ff ? CDU_WAIT : CDU_RUN;
         end
         CDU_WAIT: begin
            nxt_cnt = 14'(cnt_ff + 14'h0001);
            if (cnt_ff == 14'(PWR_WAIT - 1)) begin
               nxt_cnt = 14'h0000;
               nxt_pwr = 1'b0;
               nxt_st = CDU_FETCH;
            end
         end
         CDU_FETCH: begin
            nxt_cnt = 14'(cnt_ff + 14'h0001);
            if (cnt_ff == 14'(SE_FETCH_CYC - 1)) begin
               nxt_cnt = 14'h0000;
               nxt_se_word = fetch_w;
               nxt_st = CDU_RUN;
            end
         end
         CDU_ERASE: begin
            ee_we = 1'b1;
            ee_addr = {ptr_ff[9:5], cnt_ff[4:0]};
            ee_din = EE_BLANK;
            nxt_cnt = 14'(cnt_ff + 14'h0001);
            if (cnt_ff == 14'(PAGE_BYTES - 1)) begin
               nxt_cnt = 14'h0000;
               nxt_st = CDU_RUN;
            end
         end
         default: begin
            if (se_advance_i && se_next_idx_i != SE_RESERVED) begin
               nxt_se_idx = se_next_idx_i;
               nxt_st = CDU_FETCH;
            end
            if (new_byte) begin
               if (evt_ff.first) begin
                  if (evt_ff.data == CMD_PAGE_ERASE) begin
                     if (ctrl_ff[UPD_ERASE_EN] && in_ee(ptr_ff)) begin
                        nxt_cnt = 14'h0000;
                        nxt_st = CDU_ERASE;
                     end
                  end else if (evt_ff.data[7:2] == EE_HI_TAG) begin
                     nxt_ptr = {evt_ff.data, 8'h00};
                     nxt_exp_lo = 1'b1;
                  end else begin
                     nxt_ptr = {8'h00, evt_ff.data};
                     nxt_exp_lo = 1'b0;
                  end
               end else if (exp_lo_ff) begin
                  nxt_ptr = {ptr_ff[15:8], evt_ff.data};
                  nxt_exp_lo = 1'b0;
               end else if (in_ee(ptr_ff)) begin
                  if (ee_mem[ptr_ff[9:0]] == EE_BLANK) begin
                     ee_we = 1'b1;
                     bus_ee_wr = 1'b1;
                     if (ptr_ff[9:0] < 10'(RAM_BYTES) && ctrl_ff[UPD_TRANSP]) begin
                        a_we = 1'b1;
                        b_we = 1'b1;
                     end
                  end
               end else if (ptr_ff == {8'h00, UPD_CTRL_ADDR}) begin
                  nxt_ctrl = evt_ff.data & UPD_STORE_MASK;
                  b_copy = evt_ff.data[UPD_COMMIT];
               end else if (ptr_ff == {8'h00, UDL_ADDR}) begin
                  if (evt_ff.data[UDL_GO]) begin
                     nxt_udl = 8'h01;
                     nxt_cnt = 14'h0000;
                     nxt_st = CDU_DL;
                  end
               end else if (ptr_ff < {8'h00, RAM_LIMIT}) begin
                  a_we = 1'b1;
                  bus_ram_wr = 1'b1;
                  b_we = ctrl_ff[UPD_TRANSP];
               end
            end
         end
      endcase
      b_addr = a_addr;
      b_din = a_din;
   end

   // readback selected by the pointer
   always_comb begin
      nxt_rd_data = 8'h00;
      if (in_ee(ptr_ff)) begin
         nxt_rd_data = ee_mem[ptr_ff[9:0]];
      end else if (ptr_ff[15:8] != 8'h00) begin
         nxt_rd_data = 8'h00;
      end else if (ptr_ff[7:0] == ID_MAKER_ADDR) begin
         nxt_rd_data = MAKER_ID;
      end else if (ptr_ff[7:0] == ID_REV_ADDR) begin
         nxt_rd_data = SILICON_REV;
      end else if (ptr_ff[7:0] == ID_BRAND_MARK_ONE_ADDR) begin
         nxt_rd_data = BRAND_ONE;
      end else if (ptr_ff[7:0] == ID_BRAND_MARK_TWO_ADDR) begin
         nxt_rd_data = BRAND_TWO;
      end else if (ptr_ff[7:0] == UPD_CTRL_ADDR) begin
         nxt_rd_data = ctrl_ff;
      end else if (ptr_ff[7:0] == UDL_ADDR) begin
         nxt_rd_data = udl_ff;
      end else if (ptr_ff[7:0] < RAM_LIMIT) begin
         nxt_rd_data = latch_a[ptr_ff[7:0]];
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= CDU_DL;
         cnt_ff <= 14'h0000;
         ptr_ff <= 16'h0000;
         exp_lo_ff <= 1'b0;
         pwr_ff <= 1'b1;
         busy_ff <= 1'b1;
         ctrl_ff <= UPD_CTRL_RST;
         udl_ff <= UDL_RST;
         se_idx_ff <= 6'h00;
         se_word_ff <= 64'h0000000000000000;
         rd_data_ff <= 8'h00;
         cfg_rd_ff <= 8'h00;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         ptr_ff <= nxt_ptr;
         exp_lo_ff <= nxt_exp_lo;
         pwr_ff <= nxt_pwr;
         busy_ff <= (nxt_st != CDU_RUN);
         ctrl_ff <= nxt_ctrl;
         udl_ff <= nxt_udl;
         se_idx_ff <= nxt_se_idx;
         se_word_ff <= nxt_se_word;
         rd_data_ff <= nxt_rd_data;
         cfg_rd_ff <= (cfg_rd_addr_i < RAM_LIMIT) ? latch_b[cfg_rd_addr_i] : 8'h00;
      end
   end

   // store starts blank; real parts keep it across power cycles
   initial begin
      for (int i = 0; i < EE_BYTES; i++) begin
         ee_mem[i] = EE_BLANK;
      end
   end

   // latch pair writes; a copy then an own write lets the write win
   always_ff @(posedge clk_sys_i) begin
      if (a_we) begin
         latch_a[a_addr] <= a_din;
      end
      if (b_copy) begin
         for (int i = 0; i < RAM_BYTES; i++) begin
            latch_b[i] <= latch_a[i];
         end
      end
      if (b_we) begin
         latch_b[b_addr] <= b_din;
      end
      if (ee_we) begin
         ee_mem[ee_addr] <= ee_din;
      end
   end

   assign sda_o = sda_o_ff;
   assign sda_drv_n_o = drv_n_ff;
   assign se_state_o = se_word_ff;
   assign se_index_o = se_idx_ff;
   assign cfg_rd_data_o = cfg_rd_ff;
   assign dl_busy_o = busy_ff;

   // checks on the system side
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   AST_XFER_COPY: assert property ((st_ff == CDU_XFER) |=> latch_b[0] == latch_a[0])
      else $error("A to B copy missing");
   AST_DL_BUSY: assert property ((st_ff == CDU_DL) |=> busy_ff)
      else $error("bus not refused during download");
   AST_WAIT_FETCH: assert property ((st_ff == CDU_XFER && pwr_ff) |=>
      (st_ff == CDU_WAIT) ##1 (st_ff == CDU_WAIT))
      else $error("no settle wait after power-up download");
   AST_IMMED: assert property ((bus_ram_wr && ctrl_ff[UPD_TRANSP]) |=>
      latch_b[$past(a_addr)] == $past(a_din))
      else $error("open latch write did not reach B");
   AST_STAGED: assert property ((bus_ram_wr && !ctrl_ff[UPD_TRANSP]) |-> !b_we)
      else $error("staged write touched B");
   AST_COMMIT: assert property ((new_byte && st_ff == CDU_RUN && !evt_ff.first && !exp_lo_ff
      && ptr_ff == {8'h00, UPD_CTRL_ADDR} && evt_ff.data[UPD_COMMIT]) |-> b_copy)
      else $error("commit write gave no copy pulse");
   AST_ERASE_GATE: assert property ((st_ff == CDU_ERASE) |-> ctrl_ff[UPD_ERASE_EN])
      else $error("erase ran while disabled");
   AST_BLANK: assert property (bus_ee_wr |-> ee_mem[ee_addr] == EE_BLANK)
      else $error("write to programmed byte");
   AST_FETCH_TIME: assert property ($rose(st_ff == CDU_FETCH) |->
      ##[FETCH_LO:FETCH_HI] (st_ff == CDU_RUN))
      else $error("state fetch time wrong");
   AST_HALT: assert property ((st_ff == CDU_DL) |=> $stable(se_word_ff))
      else $error("engine moved during download");

   COV_PWRUP: cover property ((st_ff == CDU_FETCH) ##1 (st_ff == CDU_RUN));
   COV_USER_DL: cover property ($rose(udl_ff[UDL_GO]));
   COV_ERASE: cover property ($rose(st_ff == CDU_ERASE));
   COV_COMMIT: cover property (b_copy && st_ff == CDU_RUN);
endmodule : cdu_top

// *** tb/cdu_smb_master.sv ***
// bus master model: makes the link clock and drives the data line as open drain
// assumes the bench resolves the wired data line and returns it on sda_i
`timescale 1ns/100ps
module cdu_smb_master (
   // bus lines, 1 on sda_rel_o means released
   output logic scl_o,
   output logic sda_rel_o,
   input wire logic sda_i
);
   // idle high; the clock stands still between frames
   initial begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
   end
   // start, also used as repeated start
   task start();
      sda_rel_o = 1'b1;
      #16 scl_o = 1'b1;
      #16 sda_rel_o = 1'b0;
      #16 scl_o = 1'b0;
      #16;
   endtask : start
   // one 64 ns pulse, data set in the low phase, sampled at rising edge
   task pulse(input logic b, output logic s);
      sda_rel_o = b;
      #16 scl_o = 1'b1;
      s = sda_i;
      #32 scl_o = 1'b0;
      #16;
   endtask : pulse
   // byte out msb first; ack low means taken
   task wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         pulse(b[i], s);
      end
      pulse(1'b1, ack);
   endtask : wbyte
   // byte in, ended by a no acknowledge
   task rbyte(output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, s);
         b[i] = s;
      end
      pulse(1'b1, s);
   endtask : rbyte
   // stop, then the line rests high
   task stop();
      sda_rel_o = 1'b0;
      #16 scl_o = 1'b1;
      #16 sda_rel_o = 1'b1;
      #32;
   endtask : stop
endmodule : cdu_smb_master

// *** tb/tb.sv ***
// bench: power-up download, staged updates, store access, sequencer fetch
// assumes the package, the master model and a short power-up wait
`timescale 1ns/100ps
module tb;
   import cdu_pkg::*;
   logic clk_sys_i = 1'b0;
   // reset is raised just after time zero so the link side sees a real edge
   logic rst_i = 1'b0;
   logic pin_hi = 1'b1;
   logic pin_lo = 1'b0;
   logic scl, rel, sda, sda_o, sda_drv_n_o, dl_busy_o, ack;
   logic se_advance_i = 1'b0;
   logic [5:0] se_next_idx_i = 6'h00;
   logic [5:0] se_index_o;
   logic [63:0] se_state_o;
   logic [7:0] cfg_rd_addr_i = 8'h00;
   logic [7:0] cfg_rd_data_o, d;
   logic [7:0] ids [4] = '{8'h5A, 8'h12, 8'h34, 8'h56};
   int errors = 0;
   int compares = 0;
   int n;
   time t0;
   // open drain data line with pull-up
   assign sda = rel & (sda_drv_n_o | sda_o);
   cdu_smb_master u_mst (.scl_o(scl), .sda_rel_o(rel), .sda_i(sda));
   cdu_top #(.PWR_WAIT(8), .MAKER_ID(8'h5A), .SILICON_REV(8'h12), .BRAND_ONE(8'h34),
      .BRAND_TWO(8'h56)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_clk_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_drv_n_o(sda_drv_n_o), .addr_select_hi_pin_i(pin_hi),
      .addr_select_lo_pin_i(pin_lo), .se_advance_i(se_advance_i),
      .se_next_idx_i(se_next_idx_i), .se_state_o(se_state_o), .se_index_o(se_index_o),
      .cfg_rd_addr_i(cfg_rd_addr_i), .cfg_rd_data_o(cfg_rd_data_o), .dl_busy_o(dl_busy_o));
   // 20 MHz system clock
   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // bounded wait until the loader is back in run
   task idle();
      n = 0;
      while (dl_busy_o !== 1'b0 && n < 5000) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 5000) begin
         chk("busy timeout", 1'b1, 1'b0);
         wrap_up();
      end
      repeat (8) @(negedge clk_sys_i);
   endtask : idle
   // write frame of cnt bytes, msb byte first; nak expects the address refused
   task wr(input logic [7:0] a, input logic [23:0] b, input int cnt, input logic nak);
      u_mst.start();
      u_mst.wbyte(a, ack);
      chk("addr ack", ack, nak);
      for (int i = cnt - 1; i >= 0; i--) begin
         u_mst.wbyte(b[8*i +: 8], ack);
         if (!nak) chk("data ack", ack, 1'b0);
      end
      u_mst.stop();
      repeat (10) @(negedge clk_sys_i);
   endtask : wr
   // set the pointer, then read one byte after a fresh start
   task rd(input logic [23:0] p, input int cnt, output logic [7:0] v);
      wr(8'h6C, p, cnt, 1'b0);
      u_mst.start();
      u_mst.wbyte(8'h6D, ack);
      chk("read ack", ack, 1'b0);
      u_mst.rbyte(v);
      u_mst.stop();
   endtask : rd
   // main sequence
   initial begin
      #1 rst_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      rst_i = 1'b0;
      t0 = $time;
      wr(8'h6C, 24'h10AB, 2, 1'b1);
      idle();
      chk("powerup time", ($time - t0) / 50 - 8 >= RAM_BYTES + 9 + SE_FETCH_CYC, 1'b1);
      chk("first slot", se_index_o, 6'h00);
      chk("first word", se_state_o, {64{1'b1}});
      cfg_rd_addr_i = 8'h10;
      wr(8'hD0, 24'h0, 0, 1'b1);
      chk("cfg after download", cfg_rd_data_o, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         rd(24'(32'hF4 + i), 1, d);
         chk("id reg", d, ids[i]);
      end
      // other pin levels move the answering address
      @(negedge clk_sys_i);
      pin_hi = 1'b0;
      pin_lo = 1'b1;
      wr(8'h6A, 24'h0, 0, 1'b0);
      wr(8'h6C, 24'h0, 0, 1'b1);
      pin_hi = 1'b1;
      pin_lo = 1'b0;
      wr(8'h6C, 24'h9000, 2, 1'b0);
      wr(8'h6C, 24'h10AB, 2, 1'b0);
      chk("B staged", cfg_rd_data_o, 8'hFF);
      rd(24'h10, 1, d);
      chk("A staged", d, 8'hAB);
      wr(8'h6C, 24'h9002, 2, 1'b0);
      chk("B commit", cfg_rd_data_o, 8'hAB);
      wr(8'h6C, 24'h9001, 2, 1'b0);
      wr(8'h6C, 24'h10C5, 2, 1'b0);
      chk("B open", cfg_rd_data_o, 8'hC5);
      wr(8'h6C, 24'hD801, 2, 1'b0);
      idle();
      chk("user download", cfg_rd_data_o, 8'hFF);
      cfg_rd_addr_i = 8'h20;
      wr(8'h6C, 24'hF8203C, 3, 1'b0);
      chk("store to cfg", cfg_rd_data_o, 8'h3C);
      wr(8'h6C, 24'hF82011, 3, 1'b0);
      wr(8'h6C, 24'hFE, 1, 1'b0);
      idle();
      rd(24'hF820, 2, d);
      chk("no rewrite or erase", d, 8'h3C);
      wr(8'h6C, 24'h9005, 2, 1'b0);
      wr(8'h6C, 24'hF820, 2, 1'b0);
      wr(8'h6C, 24'hFE, 1, 1'b0);
      idle();
      rd(24'hF820, 2, d);
      chk("page erased", d, 8'hFF);
      // whole state word of slot 1, byte k holds 70 plus k
      for (int k = 0; k < 8; k++) begin
         wr(8'h6C, {16'(16'hFA08 + k), 8'(8'h70 + k)}, 3, 1'b0);
      end
      se_next_idx_i = 6'h01;
      se_advance_i = 1'b1;
      @(negedge clk_sys_i);
      se_advance_i = 1'b0;
      repeat (100) @(negedge clk_sys_i);
      chk("fetch pending", se_state_o, {64{1'b1}});
      idle();
      chk("next slot", se_index_o, 6'h01);
      chk("next word", se_state_o, 64'h7776757473727170);
      // the reserved slot is never fetched
      se_next_idx_i = 6'h3F;
      se_advance_i = 1'b1;
      @(negedge clk_sys_i);
      se_advance_i = 1'b0;
      @(negedge clk_sys_i);
      chk("reserved slot", se_index_o, 6'h01);
      wrap_up();
   end
endmodule : tb
